// ===== inc/trs_consts.vh
// Constants for the two-wire resistor-setting host controller.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
`ifndef TRS_CONSTS_VH
`define TRS_CONSTS_VH
// Device register addresses.
`define TRS_REG_RES0 8'hf8
`define TRS_REG_RES1 8'hf9
`define TRS_REG_RES2 8'hfa
`define TRS_POS_MAX 8'h7f
`define TRS_HIZ_BIT 7
// Address byte layout: six type bits, select bit, direction bit.
`define TRS_TYPE_CODE_DEF 6'h2a
`define TRS_RW_READ 1'b1
`define TRS_RW_WRITE 1'b0
// Own AXI register byte offsets.
`define TRS_OFF_CTRL 4'h0
`define TRS_OFF_STAT 4'h4
`define TRS_OFF_RDATA 4'h8
`define TRS_OFF_CFG 4'hc
// Control word fields.
`define TRS_CTRL_DATA_LSB 0
`define TRS_CTRL_REG_LSB 8
`define TRS_CTRL_CMD_LSB 16
`define TRS_CMD_WRITE 2'h1
`define TRS_CMD_READ 2'h2
`define TRS_CMD_RECOVER 2'h3
// Timing: quarter periods in core cycles (125 MHz).
`define TRS_CORE_MHZ 125
`define TRS_STD_KHZ 100
`define TRS_FAST_KHZ 400
`define TRS_QTR_STD ((`TRS_CORE_MHZ * 1000) / (4 * `TRS_STD_KHZ))
`define TRS_QTR_FAST ((`TRS_CORE_MHZ * 1000) / (4 * `TRS_FAST_KHZ))
`define TRS_TW_MS 20
`define TRS_TW_CYC (`TRS_TW_MS * `TRS_CORE_MHZ * 1000)
`define TRS_RECOVER_CLOCKS 9
`endif

// ===== src/trs_bit_engine.v
// Two-wire bit engine: makes the serial clock by division and shapes one
// start, stop, bit or recovery clock per request.
// Assumes open-drain pins resolved outside; line inputs are synchronised.
`timescale 1ns/100ps
`default_nettype none
`include "trs_consts.vh"
module trs_bit_engine
#(
   parameter QW = 12
)
(
   // Clock and reset.
   input wire i_core_clk,
   input wire i_reset,
   // Quarter period length in core cycles.
   input wire [QW-1:0] i_qtr,
   // Request: 0 start, 1 stop, 2 bit, 3 idle clock with data released.
   input wire i_go,
   input wire [1:0] i_op,
   input wire i_bit,
   output wire o_busy,
   output reg o_done,
   output reg o_rx,
   // Synchronised line levels.
   input wire i_scl,
   input wire i_sda,
   // Line drives, high pulls the line low.
   output reg o_scl_oe,
   output reg o_sda_oe
);

////////////////////////////////////////////////////////////////////////////////
reg [QW-1:0] cnt_reg;
reg [1:0] ph_reg;
reg act_reg;
reg [1:0] op_reg;
reg bit_reg;

assign o_busy = act_reg;

always @(posedge i_core_clk)
begin
   o_done <= 1'b0;
   if (i_reset)
   begin
      cnt_reg <= {QW{1'b0}};
      ph_reg <= 2'h0;
      act_reg <= 1'b0;
      op_reg <= 2'h0;
      bit_reg <= 1'b0;
      o_rx <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
   end
   else if (!act_reg)
   begin
      if (i_go)
      begin
         act_reg <= 1'b1;
         op_reg <= i_op;
         bit_reg <= i_bit;
         ph_reg <= 2'h0;
         cnt_reg <= i_qtr;
      end
   end
   else if (cnt_reg != {QW{1'b0}})
      cnt_reg <= cnt_reg - {{(QW-1){1'b0}}, 1'b1};
   // Wait while the released clock is still pulled low elsewhere.
   else if (!(ph_reg == 2'h2 && !o_scl_oe && !i_scl))
   begin
      cnt_reg <= i_qtr;
      ph_reg <= ph_reg + 2'h1;
      case (op_reg)
         2'h0:
         begin
            // Data falls while the clock stays high.
            case (ph_reg)
               2'h0: o_sda_oe <= 1'b0;
               2'h1: o_scl_oe <= 1'b0;
               2'h2: o_sda_oe <= 1'b1;
               default: o_scl_oe <= 1'b1;
            endcase
         end
         2'h1:
         begin
            // Data rises while the clock stays high.
            case (ph_reg)
               2'h0: o_sda_oe <= 1'b1;
               2'h1: o_scl_oe <= 1'b0;
               2'h2: o_sda_oe <= 1'b0;
               default: o_sda_oe <= 1'b0;
            endcase
         end
         default:
         begin
            // Data changes only while the clock is low.
            case (ph_reg)
               2'h0: o_sda_oe <= (op_reg == 2'h2) ? ~bit_reg : 1'b0;
               2'h1: o_scl_oe <= 1'b0;
               2'h2: o_rx <= i_sda;
               default: o_scl_oe <= 1'b1;
            endcase
         end
      endcase
      if (ph_reg == 2'h3)
      begin
         act_reg <= 1'b0;
         o_done <= 1'b1;
      end
   end
end

endmodule
`default_nettype wire

// ===== src/trs_host.v
// Host controller for a two-wire triple resistor-setting slave.
// Assumes the bench resolves open-drain lines from the enables; AXI4-Lite
// on the core clock; the slave's select pin level is given by software.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "trs_consts.vh"
module trs_host
#(
   parameter [5:0] TYPE_CODE = `TRS_TYPE_CODE_DEF, // Arbitrary value.
   parameter TW_CYCLES = `TRS_TW_CYC,
   parameter TWW = 22
)
(
   // Clock and reset.
   input wire i_core_clk,
   input wire i_reset,
   // AXI4-Lite write address and data.
   input wire i_awvalid,
   output wire o_awready,
   input wire [3:0] i_awaddr,
   input wire i_wvalid,
   output wire o_wready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   // AXI4-Lite write response.
   output reg o_bvalid,
   input wire i_bready,
   output reg [1:0] o_bresp,
   // AXI4-Lite read.
   input wire i_arvalid,
   output wire o_arready,
   input wire [3:0] i_araddr,
   output reg o_rvalid,
   input wire i_rready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   // Two-wire pins.
   input wire i_scl,
   output wire o_scl,
   output wire o_scl_oe,
   input wire i_sda,
   output wire o_sda,
   output wire o_sda_oe
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 4'h0, ST_WAITBUS = 4'h1, ST_START = 4'h2,
   ST_BYTE = 4'h3, ST_ACK = 4'h4, ST_STOP = 4'h5, ST_RDBYTE = 4'h6,
   ST_NACK = 4'h7, ST_RCVCLK = 4'h8, ST_WAITTW = 4'h9, ST_DONE = 4'ha;

reg [1:0] scl_s_reg, sda_s_reg;
reg [3:0] st_reg;
reg [2:0] idx_reg;
reg [3:0] bitn_reg;
reg [7:0] sh_reg;
reg [7:0] dev_reg, dat_reg, rd_reg;
reg [1:0] cmd_reg;
reg busy_reg, ack_err_reg, fast_reg, sel_reg, poll_reg;
reg [3:0] tries_reg;
reg [TWW-1:0] tw_reg;
reg aw_reg, w_reg;
reg [3:0] awa_reg;
reg [31:0] wd_reg;
reg go_reg;
reg [1:0] op_reg;
reg bit_reg;
wire eng_busy, eng_done, eng_rx, scl_oe, sda_oe;
localparam QTR_FAST_W = `TRS_QTR_FAST;
localparam QTR_STD_W = `TRS_QTR_STD;
wire [11:0] qtr = fast_reg ? QTR_FAST_W[11:0] : QTR_STD_W[11:0];
wire line_sync = eng_rx;
wire bus_idle = scl_s_reg[1] & sda_s_reg[1];

assign o_scl = 1'b0;
assign o_sda = 1'b0;
assign o_scl_oe = scl_oe;
assign o_sda_oe = sda_oe;

trs_bit_engine #(.QW(12)) u_eng
(
   .i_core_clk(i_core_clk),
   .i_reset(i_reset),
   .i_qtr(qtr),
   .i_go(go_reg),
   .i_op(op_reg),
   .i_bit(bit_reg),
   .o_busy(eng_busy),
   .o_done(eng_done),
   .o_rx(eng_rx),
   .i_scl(scl_s_reg[1]),
   .i_sda(sda_s_reg[1]),
   .o_scl_oe(scl_oe),
   .o_sda_oe(sda_oe)
);

always @(posedge i_core_clk)
begin
   if (i_reset)
   begin
      scl_s_reg <= 2'h3;
      sda_s_reg <= 2'h3;
   end
   else
   begin
      scl_s_reg <= {scl_s_reg[0], i_scl};
      sda_s_reg <= {sda_s_reg[0], i_sda};
   end
end

////////////////////////////////////////////////////////////////////////////////
// Register slave. A control write while busy is dropped but still answered.
assign o_awready = !aw_reg && !o_bvalid;
assign o_wready = !w_reg && !o_bvalid;
assign o_arready = !o_rvalid;
wire wr_fire = aw_reg && w_reg && !o_bvalid;
wire start_cmd = wr_fire && awa_reg == `TRS_OFF_CTRL && !busy_reg &&
   wd_reg[`TRS_CTRL_CMD_LSB +: 2] != 2'h0;

always @(posedge i_core_clk)
begin
   if (i_reset)
   begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awa_reg <= 4'h0;
      wd_reg <= 32'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= 2'h0;
      fast_reg <= 1'b0;
      sel_reg <= 1'b0;
   end
   else
   begin
      if (i_awvalid && o_awready)
      begin
         aw_reg <= 1'b1;
         awa_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
         w_reg <= 1'b1;
         wd_reg <= i_wdata;
      end
      if (wr_fire)
      begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         o_bvalid <= 1'b1;
         o_bresp <= (awa_reg == `TRS_OFF_CTRL || awa_reg == `TRS_OFF_CFG)
            ? 2'h0 : 2'h2;
         if (awa_reg == `TRS_OFF_CFG)
         begin
            fast_reg <= wd_reg[0];
            sel_reg <= wd_reg[1];
         end
      end
      else if (o_bvalid && i_bready)
         o_bvalid <= 1'b0;
      if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rresp <= 2'h0;
         case (i_araddr)
            `TRS_OFF_STAT: o_rdata <= {29'h0, bus_idle, ack_err_reg,
               busy_reg};
            `TRS_OFF_RDATA: o_rdata <= {24'h0, rd_reg};
            `TRS_OFF_CFG: o_rdata <= {30'h0, sel_reg, fast_reg};
            `TRS_OFF_CTRL: o_rdata <= {14'h0, cmd_reg, dev_reg, dat_reg};
            default:
            begin
               o_rdata <= 32'h0;
               o_rresp <= 2'h2;
            end
         endcase
      end
      else if (o_rvalid && i_rready)
         o_rvalid <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer. Byte index: 0 address(w), 1 register, 2 address(r), 3 data.
wire [7:0] addr_w = {TYPE_CODE, sel_reg, `TRS_RW_WRITE};
wire [7:0] addr_r = {TYPE_CODE, sel_reg, `TRS_RW_READ};
wire eng_idle = !eng_busy && !go_reg;

always @(posedge i_core_clk)
begin
   go_reg <= 1'b0;
   if (i_reset)
   begin
      st_reg <= ST_IDLE;
      idx_reg <= 3'h0;
      bitn_reg <= 4'h0;
      sh_reg <= 8'h0;
      dev_reg <= 8'h0;
      dat_reg <= 8'h0;
      rd_reg <= 8'h0;
      cmd_reg <= 2'h0;
      busy_reg <= 1'b0;
      ack_err_reg <= 1'b0;
      poll_reg <= 1'b0;
      tries_reg <= 4'h0;
      tw_reg <= {TWW{1'b0}};
      op_reg <= 2'h0;
      bit_reg <= 1'b0;
   end
   else
   case (st_reg)
      ST_IDLE:
         if (start_cmd)
         begin
            cmd_reg <= wd_reg[`TRS_CTRL_CMD_LSB +: 2];
            dev_reg <= wd_reg[`TRS_CTRL_REG_LSB +: 8];
            dat_reg <= wd_reg[`TRS_CTRL_DATA_LSB +: 8];
            busy_reg <= 1'b1;
            ack_err_reg <= 1'b0;
            tries_reg <= 4'h0;
            idx_reg <= 3'h0;
            poll_reg <= 1'b0;
            st_reg <= (wd_reg[`TRS_CTRL_CMD_LSB +: 2] == `TRS_CMD_RECOVER)
               ? ST_RCVCLK : ST_WAITBUS;
         end
      ST_WAITBUS:
         if (bus_idle)
         begin
            go_reg <= 1'b1;
            op_reg <= 2'h0;
            st_reg <= ST_START;
         end
      ST_RCVCLK:
         if (eng_idle)
         begin
            // Clock until data reads high, at most nine times.
            // The host holds the clock low here, so an idle bus never
            // shows: the start or stop is made directly instead.
            if (line_sync && tries_reg != 4'h0)
            begin
               go_reg <= 1'b1;
               op_reg <= 2'h0;
               st_reg <= ST_START;
            end
            else if (tries_reg == `TRS_RECOVER_CLOCKS)
            begin
               ack_err_reg <= 1'b1;
               go_reg <= 1'b1;
               op_reg <= 2'h1;
               st_reg <= ST_STOP;
            end
            else
            begin
               tries_reg <= tries_reg + 4'h1;
               go_reg <= 1'b1;
               op_reg <= 2'h3;
            end
         end
      ST_START:
         if (eng_done)
         begin
            if (cmd_reg == `TRS_CMD_RECOVER)
               st_reg <= ST_STOP;
            else
            begin
               sh_reg <= (idx_reg == 3'h2) ? addr_r : addr_w;
               bitn_reg <= 4'h0;
               st_reg <= ST_BYTE;
            end
            if (cmd_reg == `TRS_CMD_RECOVER)
            begin
               go_reg <= 1'b1;
               op_reg <= 2'h1;
            end
         end
      ST_BYTE:
         if (eng_idle)
         begin
            if (bitn_reg == 4'h8)
            begin
               go_reg <= 1'b1;
               op_reg <= 2'h2;
               bit_reg <= 1'b1;
               st_reg <= ST_ACK;
            end
            else
            begin
               go_reg <= 1'b1;
               op_reg <= 2'h2;
               bit_reg <= sh_reg[7];
               sh_reg <= {sh_reg[6:0], 1'b0};
               bitn_reg <= bitn_reg + 4'h1;
            end
         end
      ST_ACK:
         if (eng_done)
         begin
            go_reg <= 1'b1;
            bitn_reg <= 4'h0;
            if (line_sync)
            begin
               // No answer while the slave writes: poll again.
               if (poll_reg && idx_reg == 3'h0 && tw_reg != {TWW{1'b0}})
                  ;
               else
                  ack_err_reg <= 1'b1;
               op_reg <= 2'h1;
               st_reg <= ST_STOP;
            end
            else if (poll_reg)
            begin
               op_reg <= 2'h1;
               poll_reg <= 1'b0;
               tw_reg <= {TWW{1'b0}};
               st_reg <= ST_STOP;
            end
            else if (idx_reg == 3'h0)
            begin
               go_reg <= 1'b0;
               sh_reg <= dev_reg;
               idx_reg <= 3'h1;
               st_reg <= ST_BYTE;
            end
            else if (idx_reg == 3'h1 && cmd_reg == `TRS_CMD_WRITE)
            begin
               go_reg <= 1'b0;
               sh_reg <= dat_reg;
               idx_reg <= 3'h3;
               st_reg <= ST_BYTE;
            end
            else if (idx_reg == 3'h1) // Repeated start.
            begin
               op_reg <= 2'h0;
               idx_reg <= 3'h2;
               st_reg <= ST_START;
            end
            else if (idx_reg == 3'h2)
            begin
               op_reg <= 2'h2;
               bit_reg <= 1'b1;
               st_reg <= ST_RDBYTE;
            end
            else
            begin
               op_reg <= 2'h1;
               poll_reg <= 1'b1;
               st_reg <= ST_STOP;
            end
         end
      ST_RDBYTE:
         if (eng_done)
         begin
            sh_reg <= {sh_reg[6:0], eng_rx};
            go_reg <= 1'b1;
            op_reg <= 2'h2;
            bit_reg <= 1'b1;
            bitn_reg <= bitn_reg + 4'h1;
            if (bitn_reg == 4'h7)
               st_reg <= ST_NACK;
         end
      ST_NACK:
         if (eng_done)
         begin
            rd_reg <= sh_reg;
            go_reg <= 1'b1;
            op_reg <= 2'h1;
            st_reg <= ST_STOP;
         end
      ST_STOP:
         if (eng_done)
         begin
            // The write cycle starts at this stop.
            if (poll_reg && idx_reg == 3'h3)
            begin
               tw_reg <= TW_CYCLES[TWW-1:0];
               idx_reg <= 3'h0;
               st_reg <= ST_WAITTW;
            end
            else if (poll_reg)
               st_reg <= ST_WAITTW;
            else
               st_reg <= ST_DONE;
         end
      ST_WAITTW:
      begin
         if (tw_reg != {TWW{1'b0}})
            tw_reg <= tw_reg - {{(TWW-1){1'b0}}, 1'b1};
         // Poll once the bus is free; after the full time probes go on until one is answered, each refusal setting the error.
         if (bus_idle && eng_idle)
         begin
            go_reg <= 1'b1;
            op_reg <= 2'h0;
            st_reg <= ST_START;
         end
      end
      ST_DONE:
      begin
         busy_reg <= 1'b0;
         st_reg <= ST_IDLE;
      end
      default:
         st_reg <= ST_IDLE;
   endcase
end

endmodule
`default_nettype wire

// ===== testbench/trs_host_asserts.sv
// Checker for the two-wire host: register bus handshakes and line shaping.
// Assumes it is bound to trs_host and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module trs_host_chk
(
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Register bus.
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   // Two-wire pins.
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_scl,
   input wire logic o_sda,
   input wire logic o_scl_oe,
   input wire logic o_sda_oe
);
default clocking cb @(posedge i_core_clk); endclocking
default disable iff (i_reset);
////////////////////////////////////////
// Saturates so a long idle never wraps into a short count.
logic [9:0] hi_cnt;
always @(posedge i_core_clk)
begin
   if (i_reset || o_scl_oe)
      hi_cnt <= 10'h000;
   else if (hi_cnt != 10'h3ff)
      hi_cnt <= hi_cnt + 10'h001;
end
reset_a: assert property ($fell(i_reset) |-> !o_bvalid && !o_rvalid
   && !o_scl_oe && !o_sda_oe) else $error("outputs active after reset");
b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
   else $error("write response dropped early");
r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid)
   else $error("read data dropped early");
b_timing_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready
   |=> !o_bvalid ##1 o_bvalid) else $error("write response late");
r_timing_a: assert property (i_arvalid && o_arready |=> o_rvalid)
   else $error("read data late");
busy_block_a: assert property ((o_bvalid |-> !o_awready && !o_wready)
   and (o_rvalid |-> !o_arready))
   else $error("request taken with response pending");
pins_low_a: assert property (!o_scl && !o_sda)
   else $error("pin drives a high level");
idle_start_a:
   assert property ($rose(o_sda_oe) && !o_scl_oe |-> $past(i_sda)
      && $past(i_scl)) else $error("start on a busy bus");
stop_free_a:
   assert property ($fell(o_sda_oe) && !o_scl_oe
      |=> (!o_scl_oe && !o_sda_oe) [*8]) else $error("bus not free");
edge_apart_a:
   assert property ($changed(o_scl_oe) |-> $stable(o_sda_oe))
      else $error("data moved on a clock edge");
high_time_a:
   assert property ($rose(o_scl_oe) |-> hi_cnt >= 10'h096)
      else $error("clock high too short");
cover property (o_bvalid && i_bready);
cover property (o_rvalid && i_rready);
cover property ($rose(o_sda_oe) && !o_scl_oe);
cover property ($fell(o_sda_oe) && !o_scl_oe);
endmodule
bind trs_host trs_host_chk u_chk (.i_core_clk, .i_reset, .i_awvalid,
   .o_awready, .i_wvalid, .o_wready, .o_bvalid, .i_bready, .i_arvalid,
   .o_arready, .o_rvalid, .i_rready, .i_scl, .i_sda, .o_scl, .o_sda,
   .o_scl_oe, .o_sda_oe);
`default_nettype wire

// ===== testbench/trs_dev_model.sv
// Behavioural resistor-setting slave for the two-wire host bench.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module trs_dev_model
#(
   parameter [5:0] TYPE_CODE = 6'h2a, // Arbitrary value.
   // Shortened write time, long enough that polling is refused once.
   parameter int BUSY_NS = 40000
)
(
   // Bus lines and select pin.
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_sel,
   // Data pull-down enable.
   output logic o_sda_oe
);
////////////////////////////////////////
logic [7:0] regs [0:2] = '{8'h3c, 8'h41, 8'h92};
logic [7:0] ptr, sh, wdat, ob;
logic busy = 1'b0, st = 1'b0, wr_pend = 1'b0;
int n_busy_nak = 0;
initial o_sda_oe = 1'b0;
// Edge driven, so it follows any clock rate.
task automatic rx(output logic [7:0] b);
   repeat (8) @(posedge i_scl) b = {b[6:0], i_sda};
endtask
task automatic ack;
   @(negedge i_scl) o_sda_oe = 1'b1;
   @(negedge i_scl) o_sda_oe = 1'b0;
endtask
always
begin
   wait (st);
   st = 1'b0;
   begin : body
      rx(sh);
      if (busy || sh[7:2] != TYPE_CODE || sh[1] != i_sel)
         n_busy_nak += busy;
      else if (sh[0])
      begin
         ack;
         ob = (ptr >= 8'hf8 && ptr <= 8'hfa) ? regs[ptr - 8'hf8] : 8'h00;
         for (int i = 7; i >= 0; i--)
         begin
            o_sda_oe = !ob[i];
            @(negedge i_scl);
         end
         o_sda_oe = 1'b0;
      end
      else
      begin
         ack;
         rx(ptr);
         ack;
         rx(wdat);
         ack;
         wr_pend = 1'b1;
      end
   end
end
always @(negedge i_sda)
begin
   if (i_scl === 1'b1)
   begin
      disable body;
      o_sda_oe = 1'b0;
      st = 1'b1;
   end
end
always @(posedge i_sda)
begin
   if (i_scl === 1'b1)
   begin
      disable body;
      o_sda_oe = 1'b0;
      if (wr_pend)
      begin
         wr_pend = 1'b0;
         busy = 1'b1;
         if (ptr >= 8'hf8 && ptr <= 8'hfa)
            regs[ptr - 8'hf8] = wdat;
      end
   end
end
always @(posedge busy)
begin
   #(BUSY_NS);
   busy = 1'b0;
end
endmodule
`default_nettype wire

// ===== testbench/tb_trs_host.sv
// Self-checking bench for the two-wire host driving a device model.
// Assumes the model's type code equals the host's default.
`timescale 1ns/100ps
`default_nettype none
`include "trs_consts.vh"
module tb_trs_host;
logic i_core_clk = 1'b0, i_reset = 1'b1, sel_pin = 1'b0;
logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
logic i_arvalid = 1'b0, i_rready = 1'b0;
logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hf;
logic [31:0] i_wdata = 32'h0, rd;
logic [1:0] rsp;
wire logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, dev_oe;
wire logic o_scl, o_sda, o_scl_oe, o_sda_oe;
wire logic [1:0] o_bresp, o_rresp;
wire logic [31:0] o_rdata;
wire logic scl = !o_scl_oe;
wire logic sda = !(o_sda_oe || dev_oe);
int n_errors = 0, samples_checked = 0, cyc = 0;
////////////////////////////////////////
trs_host #(.TW_CYCLES(10000)) dut (.i_core_clk, .i_reset, .i_awvalid,
   .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb,
   .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
   .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_scl(scl), .o_scl,
   .o_scl_oe, .i_sda(sda), .o_sda, .o_sda_oe);
trs_dev_model #(.TYPE_CODE(`TRS_TYPE_CODE_DEF)) dev (.i_scl(scl),
   .i_sda(sda), .i_sel(sel_pin), .o_sda_oe(dev_oe));
always #4 i_core_clk = !i_core_clk;
task stop_test;
   if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
endtask
always @(posedge i_core_clk)
begin
   cyc <= cyc + 1;
   if (cyc == 100000)
   begin
      n_errors++;
      stop_test;
   end
end
task chk(input string name, input logic [31:0] seen, exp);
   samples_checked++;
   if (seen !== exp)
   begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
   end
endtask
task axi_wr(input logic [3:0] a, input logic [31:0] d);
   logic done;
   done = 1'b0;
   @(posedge i_core_clk);
   i_awvalid <= 1'b1;
   i_awaddr <= a;
   i_wvalid <= 1'b1;
   i_wdata <= d;
   i_bready <= 1'b1;
   while (!done)
   begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready)
         i_awvalid <= 1'b0;
      if (i_wvalid && o_wready)
         i_wvalid <= 1'b0;
      if (o_bvalid && i_bready)
      begin
         done = 1'b1;
         rsp = o_bresp;
         i_bready <= 1'b0;
      end
   end
endtask
task axi_rd(input logic [3:0] a);
   logic done;
   done = 1'b0;
   @(posedge i_core_clk);
   i_arvalid <= 1'b1;
   i_araddr <= a;
   i_rready <= 1'b1;
   while (!done)
   begin
      @(posedge i_core_clk);
      if (i_arvalid && o_arready)
         i_arvalid <= 1'b0;
      if (o_rvalid && i_rready)
      begin
         done = 1'b1;
         rd = o_rdata;
         rsp = o_rresp;
         i_rready <= 1'b0;
      end
   end
endtask
task cmd(input logic [1:0] c, input logic [7:0] r, d);
   axi_wr(`TRS_OFF_CTRL, {14'h0, c, r, d});
endtask
task wait_idle;
   do
      axi_rd(`TRS_OFF_STAT);
   while (rd[0] !== 1'b0);
endtask
task t_regs;
   axi_rd(`TRS_OFF_STAT);
   chk("stat", rd, 32'h4);
   axi_wr(`TRS_OFF_STAT, 32'h1);
   chk("bresp", {30'h0, rsp}, 32'h2);
   axi_wr(`TRS_OFF_CFG, 32'h3);
   axi_rd(`TRS_OFF_CFG);
   chk("cfg", rd, 32'h3);
   chk("rresp", {30'h0, rsp}, 32'h0);
endtask
// The second command lands while busy and must be dropped.
task t_write;
   axi_wr(`TRS_OFF_CFG, 32'h1);
   cmd(`TRS_CMD_WRITE, `TRS_REG_RES1, 8'h85);
   cmd(`TRS_CMD_WRITE, `TRS_REG_RES2, 8'h11);
   wait_idle;
   chk("stat", rd, 32'h4);
   chk("res1", dev.regs[1], 8'h85);
   chk("res2", dev.regs[2], 8'h92);
   chk("polled", dev.n_busy_nak > 0, 1);
   chk("nv_busy", dev.busy, 0);
endtask
task t_read(input logic [7:0] r, exp);
   cmd(`TRS_CMD_READ, r, 8'h00);
   wait_idle;
   chk("stat", rd, 32'h4);
   axi_rd(`TRS_OFF_RDATA);
   chk("rdata", rd, {24'h0, exp});
endtask
task t_nomatch;
   sel_pin <= 1'b1;
   axi_wr(`TRS_OFF_CFG, 32'h0);
   cmd(`TRS_CMD_WRITE, `TRS_REG_RES0, 8'h00);
   wait_idle;
   chk("stat", rd, 32'h6);
   chk("res0", dev.regs[0], 8'h3c);
endtask
task t_recover;
   sel_pin <= 1'b0;
   axi_wr(`TRS_OFF_CFG, 32'h1);
   cmd(`TRS_CMD_RECOVER, 8'h00, 8'h00);
   wait_idle;
   chk("stat", rd, 32'h4);
endtask
initial
begin
   repeat (8) @(posedge i_core_clk);
   i_reset <= 1'b0;
   t_regs;
   t_write;
   t_read(`TRS_REG_RES1, 8'h85);
   t_read(`TRS_REG_RES2, 8'h92);
   t_nomatch;
   t_recover;
   stop_test;
end
endmodule
`default_nettype wire
